// [core/bfm_ctrl.sv]
// Function
// - bad sync, code, length or parity sets error
// - non-contiguous response words set error
// - fail-safe timer expiry sets error
// - no response in 14 us sets timeout
// - loop-back self-test failure sets flag
// - flags and status evaluated every transaction
// - terminal discards data on message error
// - terminal flags bad words, declares illegal check
// - busy only after specific controller command
// - subsystem flag reports attached subsystem health
// - terminal flag covers both bus channels
// - bus failure from own flags only
// - status bits gate telemetry confirmation
// - per-terminal configuration entry kept
// - dead/alive changed only by ground command
// - vital changed only by ground command
// - reconfiguring terminal marked invalid
// - vital terminal lost both buses: level 3
// - entries held in safeguard store; here cfg_mem is a plain register array reloaded with CFG_RESET on i_sys_rst
// - own flag with valid terminal: bus unhealthy
// - revalidate by ground or handshake release
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module bfm_ctrl (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   bfm_link_if.ctrl         link,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   input  wire logic        i_loop_ok,
   input  wire logic        i_attitude_reconfig_signal,
   output logic             o_bus_unhealthy,
   output logic             o_tm_confirm,
   output logic             o_level3_reconfig,
   output logic             o_eval
);
   typedef enum logic [2:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_RECV, ST_EVAL} bfm_state_t;
   bfm_state_t  state_q;
   logic        tx_err_q, nr_err_q, lb_err_q, selftest_q;
   logic [15:0] cnt_q, fs_q;
   logic [4:0]  rt_q, sel_q, reval_rt_q;
   logic [15:0] last_sw_q;
   logic        air_s1_q, air_s2_q, air_s3_q;
   logic [5:0]  cfg_mem [bfm_pkg::RT_COUNT];
   // -------------------------------------------------
   // decode
   // -------------------------------------------------
   function automatic logic reg_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] offset);
      return strobe && addr == offset;
   endfunction : reg_hit
   wire         wr_ctrl   = reg_hit(i_wr, i_addr, bfm_pkg::REG_CTRL);
   wire         wr_sel    = reg_hit(i_wr, i_addr, bfm_pkg::REG_CFG_SEL);
   wire         wr_cmd    = reg_hit(i_wr, i_addr, bfm_pkg::REG_CFG_CMD);
   wire         wr_reval  = reg_hit(i_wr, i_addr, bfm_pkg::REG_REVAL_RT);
   wire         start     = wr_ctrl && i_wdata[bfm_pkg::CTRL_START] && state_q == ST_IDLE;
   wire         fmt_ok    = link.word_sync_ok && link.word_code_ok && link.word_len_ok;
   wire         par_ok    = ^{link.word_data, link.word_parity};
   wire         word_bad  = link.word_valid && !(fmt_ok && par_ok);
   wire         any_err   = tx_err_q | nr_err_q | lb_err_q;
   wire [5:0]   cur_cfg   = cfg_mem[rt_q];
   wire [5:0]   sel_cfg   = cfg_mem[sel_q];
   wire         air_fall  = air_s3_q & ~air_s2_q;
   wire [4:0]   ok_tm     = {last_sw_q[bfm_pkg::SW_MSG_ERR], last_sw_q[bfm_pkg::SW_BUSY],
                             last_sw_q[bfm_pkg::SW_SUBSYS], last_sw_q[bfm_pkg::SW_TERM], 1'b0};
   wire [31:0]  status_rd = {24'h00_0000, o_level3_reconfig, o_bus_unhealthy,
                             state_q == ST_IDLE, 2'b00, lb_err_q, nr_err_q, tx_err_q};
   // -------------------------------------------------
   // link drive
   // -------------------------------------------------
   assign link.cmd_valid = state_q == ST_SEND;
   assign link.cmd_rt    = rt_q;
   assign link.cmd_sent  = state_q == ST_SEND;
   // -------------------------------------------------
   // transaction sequencer
   // -------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q    <= ST_IDLE;
         tx_err_q   <= 1'b0;
         nr_err_q   <= 1'b0;
         lb_err_q   <= 1'b0;
         selftest_q <= 1'b0;
         cnt_q      <= 16'h0000;
         fs_q       <= 16'h0000;
         rt_q       <= 5'h00;
         last_sw_q  <= 16'h0000;
      end else begin
         unique case (state_q)
            ST_IDLE: if (start) begin
               tx_err_q   <= 1'b0;
               nr_err_q   <= 1'b0;
               lb_err_q   <= 1'b0;
               last_sw_q  <= 16'h0000;
               selftest_q <= i_wdata[bfm_pkg::CTRL_SELFTEST];
               rt_q       <= i_wdata[12:8];
               fs_q       <= 16'h0000;
               state_q    <= ST_SEND;
            end
            ST_SEND: begin
               if (selftest_q && !i_loop_ok) lb_err_q <= 1'b1;
               cnt_q   <= 16'h0000;
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               cnt_q <= cnt_q + 16'h0001;
               if (link.word_valid) begin
                  state_q <= ST_RECV;
                  if (word_bad) tx_err_q <= 1'b1;
                  if (link.word_is_status) last_sw_q <= link.word_data;
                  if (link.resp_end) state_q <= ST_EVAL;
               end else if (cnt_q >= 16'(bfm_pkg::RESP_TIMEOUT_CYC - 1)) begin
                  nr_err_q <= 1'b1;
                  state_q  <= ST_EVAL;
               end
            end
            ST_RECV: begin
               cnt_q <= link.word_valid ? 16'h0000 : cnt_q + 16'h0001;
               if (link.word_valid && word_bad) tx_err_q <= 1'b1;
               if (!link.word_valid && !link.resp_end) tx_err_q <= 1'b1;
               if (link.resp_end) state_q <= ST_EVAL;
            end
            ST_EVAL: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
         if (state_q == ST_WAIT || state_q == ST_RECV) begin
            fs_q <= fs_q + 16'h0001;
            if (fs_q >= 16'(bfm_pkg::FAILSAFE_CYC - 1)) begin
               tx_err_q <= 1'b1;
               state_q  <= ST_EVAL;
            end
         end
      end
   end
   // -------------------------------------------------
   // outcome evaluation
   // -------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_eval            <= 1'b0;
         o_bus_unhealthy   <= 1'b0;
         o_tm_confirm      <= 1'b0;
         o_level3_reconfig <= 1'b0;
      end else begin
         o_eval       <= state_q == ST_EVAL;
         o_tm_confirm <= state_q == ST_EVAL && !any_err && ok_tm == 5'h00;
         if (state_q == ST_EVAL && any_err && cur_cfg[bfm_pkg::CFG_VALID]) begin
            o_bus_unhealthy <= 1'b1;
         end else if (start) begin
            o_bus_unhealthy <= 1'b0;
         end
         if (wr_ctrl && i_wdata[bfm_pkg::CTRL_BOTH_FAIL] && cur_cfg[bfm_pkg::CFG_VITAL]) begin
            o_level3_reconfig <= 1'b1;
         end
      end
   end
   // -------------------------------------------------
   // configuration matrix
   // -------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sel_q      <= 5'h00;
         reval_rt_q <= 5'h00;
         air_s1_q   <= 1'b0;
         air_s2_q   <= 1'b0;
         air_s3_q   <= 1'b0;
         for (int k = 0; k < bfm_pkg::RT_COUNT; k++) cfg_mem[k] <= bfm_pkg::CFG_RESET;
      end else begin
         air_s1_q <= i_attitude_reconfig_signal;
         air_s2_q <= air_s1_q;
         air_s3_q <= air_s2_q;
         if (wr_sel) sel_q <= i_wdata[4:0];
         if (wr_reval) reval_rt_q <= i_wdata[4:0];
         if (wr_cmd) begin
            // ground command writes; alive and vital only change here
            for (int b = 0; b < 6; b++)
               if (i_wdata[8 + b]) cfg_mem[sel_q][b] <= i_wdata[b];
            if (i_wdata[8 + bfm_pkg::CMD_SET_INVALID])
               cfg_mem[sel_q][bfm_pkg::CFG_VALID] <= 1'b0;
         end
         if (air_fall) cfg_mem[reval_rt_q][bfm_pkg::CFG_VALID] <= 1'b1;
      end
   end
   // -------------------------------------------------
   // read data
   // -------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         unique case (i_addr)
            bfm_pkg::REG_STATUS:   o_rdata <= status_rd;
            bfm_pkg::REG_LAST_SW:  o_rdata <= {16'h0000, last_sw_q};
            bfm_pkg::REG_CFG_SEL:  o_rdata <= {27'h000_0000, sel_q};
            bfm_pkg::REG_CFG_DATA: o_rdata <= {26'h000_0000, sel_cfg};
            bfm_pkg::REG_REVAL_RT: o_rdata <= {27'h000_0000, reval_rt_q};
            default:               o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
endmodule : bfm_ctrl

// [core/bfm_link_if.sv]
`timescale 1ns/100ps
interface bfm_link_if;
   logic        cmd_valid;
   logic [4:0]  cmd_rt;
   logic        cmd_sent;
   logic        word_valid;
   logic [15:0] word_data;
   logic        word_is_status;
   logic        word_sync_ok;
   logic        word_code_ok;
   logic        word_len_ok;
   logic        word_parity;
   logic        resp_end;
   modport ctrl (output cmd_valid, output cmd_rt, output cmd_sent,
                 input word_valid, input word_data, input word_is_status,
                 input word_sync_ok, input word_code_ok, input word_len_ok,
                 input word_parity, input resp_end);
   modport term (input cmd_valid, input cmd_rt, input cmd_sent,
                 output word_valid, output word_data, output word_is_status,
                 output word_sync_ok, output word_code_ok, output word_len_ok,
                 output word_parity, output resp_end);
endinterface : bfm_link_if

// [core/bfm_pkg.sv]
package bfm_pkg;
   // -------------------------------------------------
   // word and timing
   // -------------------------------------------------
   localparam int          CLK_MHZ          = 100;
   localparam int          RESP_TIMEOUT_US  = 14;
   localparam int          RESP_TIMEOUT_CYC = RESP_TIMEOUT_US * CLK_MHZ;
   localparam int          FAILSAFE_CYC     = 4000;
   localparam int          GAP_MAX_CYC      = 400;
   localparam int          RT_COUNT         = 32;
   // -------------------------------------------------
   // status word bit positions
   // -------------------------------------------------
   localparam int          SW_MSG_ERR       = 10;
   localparam int          SW_BUSY          = 3;
   localparam int          SW_SUBSYS        = 2;
   localparam int          SW_TERM          = 0;
   // -------------------------------------------------
   // configuration entry fields
   // -------------------------------------------------
   localparam int          CFG_POWER_ON     = 0;
   localparam int          CFG_ALIVE        = 1;
   localparam int          CFG_CMD_WELL     = 2;
   localparam int          CFG_TM_WELL      = 3;
   localparam int          CFG_VALID        = 4;
   localparam int          CFG_VITAL        = 5;
   localparam logic [5:0]  CFG_RESET        = 6'h1E;
   // -------------------------------------------------
   // register map
   // -------------------------------------------------
   localparam logic [7:0]  REG_STATUS       = 8'h00;
   localparam logic [7:0]  REG_CTRL         = 8'h04;
   localparam logic [7:0]  REG_LAST_SW      = 8'h08;
   localparam logic [7:0]  REG_CFG_SEL      = 8'h0C;
   localparam logic [7:0]  REG_CFG_DATA     = 8'h10;
   localparam logic [7:0]  REG_CFG_CMD      = 8'h14;
   localparam logic [7:0]  REG_REVAL_RT     = 8'h18;
   localparam int          CTRL_START       = 0;
   localparam int          CTRL_SELFTEST    = 1;
   localparam int          CTRL_BOTH_FAIL   = 2;
   localparam int          CMD_WR_POWER     = 0;
   localparam int          CMD_WR_ALIVE     = 1;
   localparam int          CMD_WR_CMDH      = 2;
   localparam int          CMD_WR_TMH       = 3;
   localparam int          CMD_WR_VALID     = 4;
   localparam int          CMD_WR_VITAL     = 5;
   localparam int          CMD_SET_INVALID  = 6;
endpackage : bfm_pkg

// [core/bfm_term.sv]
`timescale 1ns/100ps
module bfm_term (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   bfm_link_if.term         link,
   input  wire logic        i_busy_cmd,
   input  wire logic        i_subsys_fault,
   input  wire logic        i_chan_a_fault,
   input  wire logic        i_chan_b_fault,
   input  wire logic        i_rx_word_bad,
   input  wire logic        i_illegal_cmd,
   input  wire logic [15:0] i_data,
   output logic             o_illegal_check,
   output logic             o_data_use,
   output logic [15:0]      o_data
);
   // -------------------------------------------------
   // status word build
   // -------------------------------------------------
   localparam logic CHECK_ILLEGAL = 1'b1;
   logic        msg_err_q;
   logic        respond_q;
   logic [15:0] status_w;
   assign o_illegal_check = CHECK_ILLEGAL;
   always_comb begin
      status_w                      = 16'h0000;
      status_w[bfm_pkg::SW_MSG_ERR] = msg_err_q;
      status_w[bfm_pkg::SW_BUSY]    = i_busy_cmd;
      status_w[bfm_pkg::SW_SUBSYS]  = i_subsys_fault;
      status_w[bfm_pkg::SW_TERM]    = i_chan_a_fault | i_chan_b_fault;
   end
   // -------------------------------------------------
   // response and data discard
   // -------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         msg_err_q  <= 1'b0;
         respond_q  <= 1'b0;
         o_data_use <= 1'b0;
         o_data     <= 16'h0000;
      end else begin
         o_data_use <= 1'b0;
         if (link.cmd_sent) begin
            msg_err_q <= i_rx_word_bad | (CHECK_ILLEGAL & i_illegal_cmd);
            respond_q <= 1'b1;
         end else begin
            respond_q <= 1'b0;
         end
         if (respond_q && !msg_err_q) begin
            o_data_use <= 1'b1;
            o_data     <= i_data;
         end
      end
   end
   assign link.word_valid     = respond_q;
   assign link.word_data      = status_w;
   assign link.word_is_status = respond_q;
   assign link.word_sync_ok   = 1'b1;
   assign link.word_code_ok   = 1'b1;
   assign link.word_len_ok    = 1'b1;
   assign link.word_parity    = ~^status_w;
   assign link.resp_end       = respond_q;
endmodule : bfm_term

// [sim/bfm_properties.sv]
`timescale 1ns/100ps
module bfm_properties (
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   input wire logic        cmd_valid,
   input wire logic [4:0]  cmd_rt,
   input wire logic        cmd_sent,
   input wire logic        word_valid,
   input wire logic [15:0] word_data,
   input wire logic        word_is_status,
   input wire logic        word_sync_ok,
   input wire logic        word_code_ok,
   input wire logic        word_len_ok,
   input wire logic        word_parity,
   input wire logic        resp_end
);
   // ---------------------------------------------
   // link protocol checks
   // ---------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   cmd_pulse_a: assert property (cmd_sent |=> !cmd_sent)
      else $error("command strobe longer than one cycle");
   cmd_qual_a: assert property (cmd_sent |-> cmd_valid)
      else $error("command sent without valid");
   resp_next_a: assert property (cmd_sent |=> word_valid && word_is_status && resp_end)
      else $error("status response missing after command");
   word_ok_a: assert property (word_valid |->
      word_sync_ok && word_code_ok && word_len_ok && ^{word_data, word_parity})
      else $error("terminal sent an invalid word");
   resp_single_a: assert property (word_valid && resp_end |=> !word_valid)
      else $error("word after response end");
   end_mark_a: assert property (resp_end |-> word_valid)
      else $error("response end without word");
   rt_hold_a: assert property (cmd_sent |=> $stable(cmd_rt) [*2])
      else $error("terminal address moved during transaction");
   no_stray_a: assert property ($rose(word_valid) |-> $past(cmd_sent))
      else $error("word without preceding command");
   cmd_c: cover property (cmd_sent);
   msg_err_c: cover property (word_valid && word_data[bfm_pkg::SW_MSG_ERR]);
   term_flag_c: cover property (word_valid && word_data[bfm_pkg::SW_TERM]);
endmodule : bfm_properties

// [sim/tb.sv]
`timescale 1ns/100ps
module tb;
   localparam logic [31:0] SW_MASK = 32'h0000_040D;
   logic        i_clk, i_sys_rst, i_wr, i_rd, i_loop_ok, i_attitude_reconfig_signal;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata, d;
   logic        o_bus_unhealthy, o_tm_confirm, o_level3_reconfig, o_eval, ill_chk;
   logic        dat_use;
   logic [15:0] dat_out, use_d, good_d;
   int          use_n, exp_use;
   logic        busy_c, subsys_f, cha_f, chb_f, rxbad, illeg;
   logic [15:0] t_data;
   logic [4:0]  rt;
   int          num_errors, compares, cyc;
   bfm_link_if u_bfm_link_if ();
   bfm_ctrl u_bfm_ctrl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(u_bfm_link_if.ctrl),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_loop_ok(i_loop_ok), .i_attitude_reconfig_signal(i_attitude_reconfig_signal),
      .o_bus_unhealthy(o_bus_unhealthy), .o_tm_confirm(o_tm_confirm),
      .o_level3_reconfig(o_level3_reconfig), .o_eval(o_eval));
   bfm_term u_bfm_term (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(u_bfm_link_if.term),
      .i_busy_cmd(busy_c), .i_subsys_fault(subsys_f), .i_chan_a_fault(cha_f),
      .i_chan_b_fault(chb_f), .i_rx_word_bad(rxbad), .i_illegal_cmd(illeg), .i_data(t_data),
      .o_illegal_check(ill_chk), .o_data_use(dat_use), .o_data(dat_out));
   bfm_properties u_bfm_properties (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .cmd_valid(u_bfm_link_if.cmd_valid), .cmd_rt(u_bfm_link_if.cmd_rt),
      .cmd_sent(u_bfm_link_if.cmd_sent), .word_valid(u_bfm_link_if.word_valid),
      .word_data(u_bfm_link_if.word_data), .word_is_status(u_bfm_link_if.word_is_status),
      .word_sync_ok(u_bfm_link_if.word_sync_ok), .word_code_ok(u_bfm_link_if.word_code_ok),
      .word_len_ok(u_bfm_link_if.word_len_ok), .word_parity(u_bfm_link_if.word_parity),
      .resp_end(u_bfm_link_if.resp_end));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic complete_run();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
   endtask : rd
   function automatic logic [31:0] ctl(input logic [4:0] r, input logic [2:0] b);
      return {19'h0_0000, r, 5'h00, b};
   endfunction : ctl
   function automatic logic [31:0] exp_sw();
      exp_sw = '0;
      exp_sw[bfm_pkg::SW_MSG_ERR] = rxbad | illeg;
      exp_sw[bfm_pkg::SW_BUSY] = busy_c;
      exp_sw[bfm_pkg::SW_SUBSYS] = subsys_f;
      exp_sw[bfm_pkg::SW_TERM] = cha_f | chb_f;
   endfunction : exp_sw
   task automatic go(input logic [31:0] c);
      int n = 0;
      wr(bfm_pkg::REG_CTRL, c);
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (o_eval !== 1'b1 && n < 3000);
      check(n < 3000, 1);
   endtask : go
   // ---------------------------------------------
   // clock, timeout and sequence
   // ---------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         complete_run();
      end
   end
   always @(negedge i_clk) begin
      if (dat_use === 1'b1) begin
         use_n <= use_n + 1;
         use_d <= dat_out;
      end
   end
   initial begin
      i_sys_rst = 1'b1;
      {i_wr, i_rd, i_addr, i_wdata, i_attitude_reconfig_signal} = '0;
      {busy_c, subsys_f, cha_f, chb_f, rxbad, illeg, t_data} = '0;
      i_loop_ok = 1'b1;
      void'($urandom(37));
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         rt = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : 5'($urandom);
         wr(bfm_pkg::REG_CFG_SEL, 32'(rt));
         rd(bfm_pkg::REG_CFG_DATA, d);
         check(d, 32'(bfm_pkg::CFG_RESET));
      end
      check(ill_chk, 1);
      rd(8'hFC, d);
      check(d, 32'h0000_0000);
      for (int k = 0; k < 12; k++) begin
         @(posedge i_clk);
         rt <= 5'($urandom);
         {busy_c, subsys_f, cha_f, chb_f, rxbad, illeg} <= (k < 2) ? 6'h00 : 6'($urandom & $urandom);
         t_data <= 16'($urandom);
         @(posedge i_clk);
         go(ctl(rt, 3'h1));
         check(o_tm_confirm, exp_sw() == 32'h0000_0000);
         check(o_bus_unhealthy, 0);
         rd(bfm_pkg::REG_LAST_SW, d);
         check(d & SW_MASK, exp_sw());
         if (!(rxbad | illeg)) begin
            exp_use++;
            good_d = t_data;
         end
         check(use_n, exp_use);
         check({16'h0000, use_d}, {16'h0000, good_d});
         rd(bfm_pkg::REG_STATUS, d);
         check(d[2:0], 0);
      end
      @(posedge i_clk);
      {busy_c, subsys_f, cha_f, chb_f, rxbad, illeg} <= 6'h00;
      i_loop_ok <= 1'b0;
      go(ctl(rt, 3'h3));
      check(o_bus_unhealthy, 1);
      check(o_tm_confirm, 0);
      rd(bfm_pkg::REG_STATUS, d);
      check(d[6] & d[2], 1);
      @(posedge i_clk);
      i_loop_ok <= 1'b1;
      go(ctl(rt, 3'h1));
      check(o_bus_unhealthy, 0);
      rd(bfm_pkg::REG_STATUS, d);
      check(d[2:0], 0);
      wr(bfm_pkg::REG_CFG_SEL, 32'(rt));
      wr(bfm_pkg::REG_CFG_CMD, 32'h0000_4000);
      rd(bfm_pkg::REG_CFG_DATA, d);
      check(d, 32'h0000_000E);
      @(posedge i_clk);
      i_loop_ok <= 1'b0;
      go(ctl(rt, 3'h3));
      check(o_bus_unhealthy, 0);
      @(posedge i_clk);
      i_loop_ok <= 1'b1;
      wr(bfm_pkg::REG_REVAL_RT, 32'(rt));
      i_attitude_reconfig_signal <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_attitude_reconfig_signal <= 1'b0;
      repeat (4) @(posedge i_clk);
      rd(bfm_pkg::REG_CFG_DATA, d);
      check(d, 32'h0000_001E);
      wr(bfm_pkg::REG_CFG_CMD, 32'h0000_0200);
      rd(bfm_pkg::REG_CFG_DATA, d);
      check(d, 32'h0000_001C);
      wr(bfm_pkg::REG_CTRL, ctl(rt, 3'h4));
      repeat (2) @(posedge i_clk);
      #1;
      check(o_level3_reconfig, 0);
      wr(bfm_pkg::REG_CFG_CMD, 32'h0000_2020);
      rd(bfm_pkg::REG_CFG_DATA, d);
      check(d, 32'h0000_003C);
      wr(bfm_pkg::REG_CFG_CMD, 32'h0000_4000);
      rd(bfm_pkg::REG_CFG_DATA, d);
      check(d, 32'h0000_002C);
      wr(bfm_pkg::REG_CFG_CMD, 32'h0000_1010);
      rd(bfm_pkg::REG_CFG_DATA, d);
      check(d, 32'h0000_003C);
      wr(bfm_pkg::REG_CTRL, ctl(rt, 3'h4));
      repeat (2) @(posedge i_clk);
      #1;
      check(o_level3_reconfig, 1);
      complete_run();
   end
endmodule : tb
